// [qesc_pkg.sv]
// constants and field layouts of the encoder status and control block
package qesc_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SEL  = 8'h04;
	localparam logic [7:0] OFS_CNT  = 8'h08;
	localparam logic [7:0] OFS_CFG  = 8'h0c;
	// ==========================================================
	// field positions
	localparam int CNT_W        = 24;
	localparam int BIT_MODE_LO  = 24;
	localparam int BIT_LIST_CLR = 26;
	localparam int BIT_HOLD     = 27;
	localparam int BIT_NOFB     = 28;
	localparam int BIT_REF_LO   = 29;
	localparam int BIT_DEC_LVL  = 0;
	localparam int BIT_DIV_LVL  = 1;
	localparam int BIT_PHA      = 24;
	localparam int BIT_PHB      = 25;
	localparam int BIT_DIR      = 26;
	localparam int BIT_INWIN    = 27;
	localparam int BIT_FRESH    = 28;
	localparam int BIT_WIN_EN   = 27;
	localparam int BIT_SINGLE   = 28;
	// ==========================================================
	// encodings and reset values
	localparam logic [2:0] REF_125MHZ  = 3'h0;
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_AUTO   = 2'h1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [23:0] LIMIT_RST  = 24'h000000;
	// ==========================================================
	// timing
	localparam int CLK_FREQ_HZ  = 10000000;
	localparam int HOLD_TIME_US = 10000;
	localparam int HOLD_CYCLES  = HOLD_TIME_US * (CLK_FREQ_HZ / 1000000);
	localparam int TMR_W        = 20;
	// ==========================================================
	// software visible control fields
	typedef struct packed {
		logic [2:0]  ref_sel;
		logic        no_feedback;
		logic        hold_level;
		logic [1:0]  clear_mode;
		logic [23:0] upper;
	} qesc_ctrl_s;
	typedef struct packed {
		logic        win_en;
		logic        single;
		logic [23:0] lower;
	} qesc_cfg_s;
endpackage

// [qesc_top.sv]
// encoder position, line-list and divider control block with an axi4-lite slave
//
// Behaviour
// [RL1] writing list-clear bit erases visited lines
// [RL2] list-clear write works in every clear mode
// [RL3] auto mode clears list once per pass; code holds it cleared every cycle the count is outside the window
// [RL4] hold-level keeps divider constant when slow
// [RL5] no-feedback runs divider without loop correction
// [RL6] reference select zero means 125 MHz
// [RL7] status bit 0 shows decoder output level
// [RL8] status bit 1 shows divider output level
// [RL9] low 24 bits show live position count
// [RL10] bit 24 shows phase A level
// [RL11] bit 25 shows phase B level
// [RL12] bit 26 shows direction, 1 positive
// [RL13] bit 27 set when inside capture window
// [RL14] bit 28 set on never visited positions
// [RL15] revisited positions clear bit 28, no capture; code tracks visits only with single set, free capture still captures
// [RL16] top three count bits reserved, read zero
// [RL17] single capture: one line per count value
// [RL18] window mode captures only between bounds
// [RL19] reset clears count, direction, list, controls
`timescale 1ns/1ps
module qesc_top
	import qesc_pkg::*;
#(
	parameter int HOLD_CYC = HOLD_CYCLES
)(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address channel
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// write data channel
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// write response channel
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read address channel
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// read data channel
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// encoder phases
	input  wire logic        phase_a,
	input  wire logic        phase_b,
	// acquisition side
	output logic             line_capture,
	output logic             decoder_out,
	output logic             divider_out
);
	localparam logic [TMR_W-1:0] HOLD_T = TMR_W'(HOLD_CYC);

	qesc_ctrl_s              ctrl;
	qesc_cfg_s               cfg;
	logic [7:0]              aw_addr;
	logic                    aw_held;
	logic [31:0]             w_data;
	logic [3:0]              w_strb;
	logic                    w_held;
	logic                    wr_go;
	logic                    list_clear;
	logic                    a_q;
	logic                    b_q;
	logic                    a_p;
	logic                    b_p;
	logic                    step;
	logic                    step_up;
	logic [CNT_W-1:0]        position_counter_value;
	logic [CNT_W-1:0]        next_cnt;
	logic                    motion_direction;
	logic                    inside_window_flag;
	logic                    fresh_position_flag;
	logic                    next_in_range;
	logic                    next_fresh;
	logic                    capture_ok;
	logic                    auto_clear;
	logic                    seen_valid;
	logic [CNT_W-1:0]        seen_lo;
	logic [CNT_W-1:0]        seen_hi;
	logic [TMR_W-1:0]        gap;
	logic [TMR_W-1:0]        period;
	logic [TMR_W-1:0]        phase_acc;
	logic                    div_slow;
	logic                    div_on;

	// ==========================================================
	// register bus
	// address and data are caught independently, in either order
	assign wr_go = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			awready <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			// no new address while a response is being formed or is pending
			awready <= !aw_held && !(awvalid && awready) && !wr_go && !bvalid;
		end
	end

	// write data holding slot
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			wready <= 1'b0;
		end
		else
		begin
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			else if (wr_go)
				w_held <= 1'b0;
			wready <= !w_held && !(wvalid && wready) && !wr_go && !bvalid;
		end
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid <= 1'b1;
			if (aw_addr == OFS_CTRL || aw_addr == OFS_SEL
				|| aw_addr == OFS_CNT || aw_addr == OFS_CFG)
				bresp <= RESP_OKAY;
			else
				bresp <= RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// control register fields, byte lanes honoured
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= '0; // see [RL19]
			cfg  <= '0;
		end
		else if (wr_go && aw_addr == OFS_CTRL)
		begin
			if (w_strb[0])
				ctrl.upper[7:0] <= w_data[7:0];
			if (w_strb[1])
				ctrl.upper[15:8] <= w_data[15:8];
			if (w_strb[2])
				ctrl.upper[23:16] <= w_data[23:16];
			if (w_strb[3])
			begin
				ctrl.clear_mode  <= w_data[BIT_MODE_LO+:2];
				ctrl.hold_level  <= w_data[BIT_HOLD];
				ctrl.no_feedback <= w_data[BIT_NOFB];
				ctrl.ref_sel     <= w_data[BIT_REF_LO+:3];
			end
		end
		else if (wr_go && aw_addr == OFS_CFG)
		begin
			if (w_strb[0])
				cfg.lower[7:0] <= w_data[7:0];
			if (w_strb[1])
				cfg.lower[15:8] <= w_data[15:8];
			if (w_strb[2])
				cfg.lower[23:16] <= w_data[23:16];
			if (w_strb[3])
			begin
				cfg.win_en <= w_data[BIT_WIN_EN];
				cfg.single <= w_data[BIT_SINGLE];
			end
		end
	end

	// list clear is a write strobe only, never stored; any mode honours it
	assign list_clear = wr_go && aw_addr == OFS_CTRL && w_strb[3]
		&& w_data[BIT_LIST_CLR]; // see [RL1] see [RL2]

	// read channel, one outstanding read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rresp  <= RESP_OKAY;
				rdata  <= 32'h00000000;
				if (araddr == OFS_CTRL)
					rdata <= {ctrl.ref_sel, ctrl.no_feedback, ctrl.hold_level,
						1'b0, ctrl.clear_mode, ctrl.upper};
				else if (araddr == OFS_SEL)
					rdata <= {30'h00000000, divider_out,
						decoder_out}; // see [RL7] see [RL8]
				else if (araddr == OFS_CNT)
					rdata <= {2'h0, 1'b0, fresh_position_flag, // see [RL16]
						inside_window_flag, motion_direction, b_q, a_q,
						position_counter_value}; // see [RL9] see [RL10] see [RL11]
				else if (araddr == OFS_CFG)
					rdata <= {3'h0, cfg.single, cfg.win_en, 3'h0, cfg.lower};
				else
					rresp <= RESP_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// quadrature decoding, 4x
	// a legal step flips exactly one phase; a double flip is dropped
	assign step    = (a_q ^ a_p) != (b_q ^ b_p);
	assign step_up = a_p ^ b_q;
	assign next_cnt = step_up ? position_counter_value + 24'h000001
		: position_counter_value - 24'h000001;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			a_p <= 1'b0;
			b_p <= 1'b0;
			position_counter_value <= 24'h000000; // see [RL19]
			motion_direction <= 1'b0;
			decoder_out <= 1'b0;
		end
		else
		begin
			a_q <= phase_a;
			b_q <= phase_b;
			a_p <= a_q;
			b_p <= b_q;
			if (step)
			begin
				position_counter_value <= next_cnt;
				motion_direction <= step_up; // see [RL12]
				decoder_out <= !decoder_out;
			end
		end
	end

	// ==========================================================
	// window and visited-line tracking
	assign next_in_range = next_cnt >= cfg.lower && next_cnt <= ctrl.upper;
	// visited positions form one contiguous span, since the count moves by one
	assign next_fresh = !seen_valid || next_cnt > seen_hi || next_cnt < seen_lo;
	assign capture_ok = (!cfg.win_en || next_in_range) // see [RL18]
		&& (!cfg.single || next_fresh); // see [RL15] see [RL17]
	// auto mode keeps the list cleared on every cycle that the count is outside the window
	assign auto_clear = ctrl.clear_mode == MODE_AUTO
		&& !(position_counter_value >= cfg.lower
		&& position_counter_value <= ctrl.upper); // see [RL3]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			seen_valid <= 1'b0; // see [RL19]
			seen_lo    <= LIMIT_RST;
			seen_hi    <= LIMIT_RST;
		end
		else if (step && capture_ok && cfg.single)
		begin
			// a capture in the clear cycle starts the new list, so it is kept
			seen_valid <= 1'b1;
			if (!seen_valid || list_clear || auto_clear)
			begin
				seen_lo <= next_cnt;
				seen_hi <= next_cnt;
			end
			else if (next_cnt > seen_hi)
				seen_hi <= next_cnt;
			else
				seen_lo <= next_cnt;
		end
		else if (list_clear || auto_clear)
			seen_valid <= 1'b0; // see [RL1] see [RL3]
	end

	// capture strobe and status flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_capture <= 1'b0;
			inside_window_flag <= 1'b0;
			fresh_position_flag <= 1'b0;
		end
		else
		begin
			line_capture <= step && capture_ok; // see [RL17] see [RL18]
			if (step)
			begin
				inside_window_flag <= cfg.win_en && next_in_range; // see [RL13]
				fresh_position_flag <= next_fresh; // see [RL14] see [RL15]
			end
			else if (!cfg.win_en)
				inside_window_flag <= 1'b0;
			if (!step && (list_clear || auto_clear))
				fresh_position_flag <= 1'b1;
		end
	end

	// ==========================================================
	// encoder divider
	// only the 125 MHz reference is supported; reserved selects stop it
	assign div_on   = ctrl.ref_sel == REF_125MHZ; // see [RL6]
	assign div_slow = gap == HOLD_T;

	// step spacing measurement, saturating at the slow threshold
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gap    <= '0;
			period <= '0;
		end
		else if (step)
		begin
			gap    <= '0;
			period <= gap;
		end
		else if (!div_slow)
			gap <= gap + 20'h00001;
	end

	// closed loop follows each step; open loop free-runs on the last period
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			divider_out <= 1'b0;
			phase_acc   <= '0;
		end
		else if (!div_on)
		begin
			divider_out <= 1'b0;
			phase_acc   <= '0;
		end
		else if (ctrl.hold_level && div_slow)
		begin
			phase_acc <= '0; // see [RL4]
		end
		else if (ctrl.no_feedback)
		begin
			// no resync to steps: drift is the price of open loop
			if (phase_acc >= period)
			begin
				phase_acc   <= '0;
				divider_out <= !divider_out; // see [RL5]
			end
			else
				phase_acc <= phase_acc + 20'h00001;
		end
		else if (step)
			divider_out <= !divider_out;
	end
endmodule

// [qesc_top_props.sv]
// port checks for the encoder status block
`timescale 1ns/1ps
module qesc_top_props
	import qesc_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	// encoder side
	input wire logic        phase_a,
	input wire logic        phase_b,
	input wire logic        line_capture,
	input wire logic        decoder_out
);
	// ==========================================================
	// timing relations
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// both write halves taken at one edge
	sequence s_wtake;
		awvalid && awready && wvalid && wready;
	endsequence
	// one phase moved; both at once is ignored by the decoder
	sequence s_step;
		$past(aresetn) && ($changed(phase_a) ^ $changed(phase_b));
	endsequence
	a_write_answer: assert property (s_wtake |=> ##1 bvalid)
		else $error("write answer late");
	a_bvalid_stands: assert property (bvalid && !bready |=> bvalid)
		else $error("bvalid dropped");
	a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer moved");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	a_read_blocked: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_reset_quiet: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !line_capture)
		else $error("outputs busy after reset");
	a_step_toggle: assert property (s_step |-> ##2 $changed(decoder_out))
		else $error("decoder output missed a step");
	a_capture_step: assert property (line_capture |-> decoder_out != $past(decoder_out))
		else $error("capture without a step");
endmodule
bind qesc_top qesc_top_props u_props (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .phase_a, .phase_b,
	.line_capture, .decoder_out
);

// [qesc_enc_model.sv]
// shaft encoder model driving the two phase lines
`timescale 1ns/1ps
module qesc_enc_model (
	// clock
	input wire logic aclk,
	// phase lines
	output logic     phase_a,
	output logic     phase_b
);
	// ==========================================================
	// gray position, only one phase moves per step
	logic [1:0] pos = 2'h0;
	assign phase_a = pos[1];
	assign phase_b = pos[1] ^ pos[0];
	// n steps, up when positive, gap cycles apart
	task automatic move(input int n, input int gap);
		repeat (n < 0 ? -n : n)
		begin
			repeat (gap) @(posedge aclk);
			pos <= (n < 0) ? pos - 2'h1 : pos + 2'h1;
		end
	endtask
endmodule

// [qesc_top_bench.sv]
// self-checking bench for the encoder status block
`timescale 1ns/1ps
module qesc_top_bench import qesc_pkg::*;;
	// ==========================================================
	// wires and bench state
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, phase_a, phase_b, line_capture, dir;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          errors, compares, caps, exp_caps, cyc, cnt;
	localparam logic [31:0] CLR = 32'h04000000;
	localparam logic [31:0] AUTO = 32'h190000ff;
	qesc_top #(.HOLD_CYC(20)) dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .phase_a, .phase_b, .line_capture,
		.decoder_out(), .divider_out()
	);
	qesc_enc_model u_enc (.aclk, .phase_a, .phase_b);
	// 100 ns clock
	initial aclk = 1'h0;
	always #50 aclk = ~aclk;
	// count captures; the ceiling cuts a hang short
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (line_capture === 1'h1)
			caps <= caps + 1;
		if (cyc == 20000)
		begin
			errors = errors + 1;
			test_done();
		end
	end
	// ==========================================================
	// helpers
	task automatic test_done();
		if (errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad;
		logic dd;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		ad = 1'h0;
		dd = 1'h0;
		do
		begin
			@(posedge aclk);
			ad = ad | awready;
			dd = dd | wready;
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (!(ad && dd));
		while (!bvalid) @(posedge aclk);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		while (!rvalid) @(posedge aclk);
		chk(rdata & m, e);
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'h0;
	endtask
	// move the shaft, then let the two-edge decode settle
	task automatic st(input int n, input int gap, input int nc);
		u_enc.move(n, gap);
		cnt = cnt + n;
		dir = (n > 0);
		exp_caps = exp_caps + nc;
		repeat (5) @(posedge aclk);
		chk(caps, exp_caps);
	endtask
	// expected count status from the bench's own position
	function automatic logic [31:0] stat(input logic in_w, input logic fr);
		logic [23:0] c;
		c = cnt[23:0];
		return {3'h0, fr, in_w, dir, c[1] ^ c[0], c[1], c};
	endfunction
	// ==========================================================
	// main sequence
	initial
	begin
		{errors, compares, caps, exp_caps, cyc, cnt} = '0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, dir} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rd(OFS_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
		rd(OFS_CNT, 32'h0, 32'h0fffffff, RESP_OKAY);
		rd(OFS_CFG, 32'h0, 32'hffffffff, RESP_OKAY);
		rd(8'h10, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h10, 32'hffffffff, RESP_SLVERR);
		wr(OFS_SEL, 32'hffffffff, RESP_OKAY);
		rd(OFS_SEL, 32'h0, 32'hffffffff, RESP_OKAY);
		// free capture, back to back then slow
		st(5, 1, 5);
		rd(OFS_CNT, stat(1'h0, 1'h0), 32'hefffffff, RESP_OKAY);
		st(-2, 4, 2);
		rd(OFS_CNT, stat(1'h0, 1'h0), 32'hefffffff, RESP_OKAY);
		rd(OFS_SEL, 32'h3, 32'hffffffff, RESP_OKAY);
		// one line per position, manual clearing
		wr(OFS_CFG, 32'h10000000, RESP_OKAY);
		wr(OFS_CTRL, CLR, RESP_OKAY);
		rd(OFS_CNT, stat(1'h0, 1'h1), 32'hffffffff, RESP_OKAY);
		st(2, 2, 2);
		st(-1, 2, 0);
		rd(OFS_CNT, stat(1'h0, 1'h0), 32'hffffffff, RESP_OKAY);
		st(1, 1, 0);
		st(1, 1, 1);
		wr(OFS_CTRL, CLR, RESP_OKAY);
		st(-1, 1, 1);
		// automatic mode, cleared by a write too
		wr(OFS_CTRL, AUTO, RESP_OKAY);
		rd(OFS_CTRL, AUTO, 32'hffffffff, RESP_OKAY);
		st(1, 1, 1);
		st(-1, 1, 0);
		wr(OFS_CTRL, AUTO | CLR, RESP_OKAY);
		rd(OFS_CTRL, AUTO, 32'hffffffff, RESP_OKAY);
		st(1, 1, 1);
		// upper bound below the count: automatic clear outside
		wr(OFS_CTRL, 32'h19000003, RESP_OKAY);
		st(-1, 1, 1);
		st(1, 1, 1);
		// capture window of one position, other reference clock
		wr(OFS_CTRL, 32'h20000008, RESP_OKAY);
		wr(OFS_CFG, 32'h08000008, RESP_OKAY);
		st(1, 1, 0);
		st(1, 1, 1);
		rd(OFS_CNT, stat(1'h1, 1'h0), 32'hefffffff, RESP_OKAY);
		st(1, 1, 0);
		rd(OFS_CNT, stat(1'h0, 1'h0), 32'hefffffff, RESP_OKAY);
		rd(OFS_SEL, 32'h0, 32'h2, RESP_OKAY);
		test_done();
	end
endmodule
